//--- inc/bdcis_regs.vh
// Register offsets, command codes, field positions and timing figures of the bias DAC sequencer.
`ifndef BDCIS_REGS_VH
`define BDCIS_REGS_VH

// ====================================================================
// Register offsets
`define BDCIS_ADDR_CONV_CFG 8'h30
`define BDCIS_ADDR_AMP_CAL 8'h4e
`define BDCIS_ADDR_POWER 8'h64
`define BDCIS_ADDR_CLEAR 8'h68
`define BDCIS_ADDR_UPPER 8'h10
`define BDCIS_ADDR_LOWER 8'h12
`define BDCIS_ADDR_FINE_BUF 8'h14
`define BDCIS_ADDR_FINE_BUF_CAL 8'h16
`define BDCIS_ADDR_FINE_DIRECT_CAL 8'h18
`define BDCIS_ADDR_DIRECT_DAC 8'h1a
`define BDCIS_ADDR_LOAD 8'h1c
`define BDCIS_ADDR_STATUS 8'h1e

// ====================================================================
// Command codes and reset values
`define BDCIS_POWER_TOGGLE 16'h0080
`define BDCIS_CLEAR_ARM 16'h0100
`define BDCIS_CLEAR_COMPLETE 16'h0200
`define BDCIS_AMP_CAL_GO 16'h0002
`define BDCIS_CONV_CFG_RST 16'h0000
`define BDCIS_POWER_RST 16'h0000
`define BDCIS_ZERO16 16'h0000

// ====================================================================
// Field positions and widths
`define BDCIS_REF_DAC_BIT 3
`define BDCIS_REF_ADC_BIT 1
`define BDCIS_WIPER_CAL_BIT 8
`define BDCIS_COARSE_W 8
`define BDCIS_FINE_W 10

// ====================================================================
// Timing
`define BDCIS_CLK_KHZ 40000
`define BDCIS_AMP_CAL_MS 30
`define BDCIS_DAC_CAL_CYCLES 64
`define BDCIS_CONV_CYCLES 16

`endif

//--- core/bdcis_cal_engine.v
// Shared converter and arithmetic engine, arbitrated between calibration jobs and conversions.
`timescale 1ns/1ps
`default_nettype none

module bdcis_cal_engine #(
  parameter NJOB = 6,
  parameter CW = 24,
  parameter [CW-1:0] AMP_CYCLES = 24'h12_4f80,
  parameter [CW-1:0] CAL_CYCLES = 24'h00_0040,
  parameter [CW-1:0] CONV_CYCLES = 24'h00_0010
) (
  input wire clk,
  input wire resetn,
  input wire abort,
  input wire [NJOB-1:0] req,
  output reg active_q,
  output reg [NJOB-1:0] done_q
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_RUN = 3'b010;
  localparam [2:0] S_DONE = 3'b100;

  reg [2:0] state_q;
  reg [NJOB-1:0] job_q;
  reg [CW-1:0] cnt_q;
  reg [NJOB-1:0] sel_d;
  reg found;
  reg [CW-1:0] len_d;
  integer i;

  // ====================================================================
  // Fixed priority: amplifier calibration, coarse, fine, then conversions.
  always @* begin
    sel_d = {NJOB{1'b0}};
    found = 1'b0;
    for (i = 0; i < NJOB; i = i + 1) begin
      if (req[i] && !found) begin
        sel_d[i] = 1'b1;
        found = 1'b1;
      end
    end
    if (sel_d[0]) begin
      len_d = AMP_CYCLES;
    end else if (sel_d[NJOB-1]) begin
      len_d = CONV_CYCLES;
    end else begin
      len_d = CAL_CYCLES;
    end
  end

  // ====================================================================
  // Job sequencer.
  // The one-cycle pause after a job gives the requester time to drop its
  // request, so a finished job is never granted a second time.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      job_q <= {NJOB{1'b0}};
      cnt_q <= {CW{1'b0}};
      active_q <= 1'b0;
      done_q <= {NJOB{1'b0}};
    end else if (abort) begin
      state_q <= S_IDLE;
      job_q <= {NJOB{1'b0}};
      cnt_q <= {CW{1'b0}};
      active_q <= 1'b0;
      done_q <= {NJOB{1'b0}};
    end else begin
      case (state_q)
        S_IDLE: begin
          done_q <= {NJOB{1'b0}};
          if (found) begin
            job_q <= sel_d;
            cnt_q <= len_d - {{(CW-1){1'b0}}, 1'b1};
            active_q <= 1'b1;
            state_q <= S_RUN;
          end
        end
        S_RUN: begin
          if (cnt_q == {CW{1'b0}}) begin
            done_q <= job_q;
            active_q <= 1'b0;
            state_q <= S_DONE;
          end else begin
            cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
          end
        end
        S_DONE: begin
          done_q <= {NJOB{1'b0}};
          job_q <= {NJOB{1'b0}};
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- core/bdcis_core.v
// Register command sequencer of a dual-channel gate-bias controller.
`timescale 1ns/1ps
`default_nettype none
`include "bdcis_regs.vh"

module bdcis_core #(
  parameter NCH = 2,
  parameter AMP_CAL_CYCLES = `BDCIS_AMP_CAL_MS * `BDCIS_CLK_KHZ,
  parameter DAC_CAL_CYCLES = `BDCIS_DAC_CAL_CYCLES,
  parameter CONV_CYCLES = `BDCIS_CONV_CYCLES
) (
  input wire clk,
  input wire resetn,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [15:0] wr_data,
  input wire rd_en,
  input wire [7:0] rd_addr,
  output reg [15:0] rd_data_q,
  output reg rd_valid_q,
  input wire conv_req,
  output wire conv_done,
  output wire [NCH*`BDCIS_COARSE_W-1:0] upper_dac,
  output wire [NCH*`BDCIS_COARSE_W-1:0] lower_dac,
  output wire [NCH*`BDCIS_FINE_W-1:0] fine_dac,
  output reg powered_q,
  output reg dac_int_ref_q,
  output reg adc_int_ref_q,
  output reg soft_reset_q,
  output reg busy_q
);

  localparam NJOB = 2 * NCH + 2;
  localparam CW = 24;
  localparam CWV = `BDCIS_COARSE_W;
  localparam FWV = `BDCIS_FINE_W;

  reg [15:0] conv_cfg_q;
  reg [15:0] power_q;
  reg clear_armed_q;
  reg [1:0] reset_count_q;
  reg amp_pend_q;
  wire wr_ok;
  wire [NJOB-1:0] eng_req;
  wire [NJOB-1:0] eng_done;
  wire eng_active;
  wire [NCH-1:0] ch_pend;
  wire [NCH-1:0] ch_coarse_run;
  wire [NCH-1:0] ch_fine_pend;

  // While global power is removed only the power register is honoured.
  assign wr_ok = wr_en && powered_q;

  // ====================================================================
  // Global control registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_q <= `BDCIS_POWER_RST;
      powered_q <= 1'b1;
      conv_cfg_q <= `BDCIS_CONV_CFG_RST;
      dac_int_ref_q <= 1'b0;
      adc_int_ref_q <= 1'b0;
      clear_armed_q <= 1'b0;
      reset_count_q <= 2'b00;
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= 1'b0;
      if (wr_en && wr_addr == `BDCIS_ADDR_POWER) begin
        power_q <= wr_data;
        if (wr_data == `BDCIS_POWER_TOGGLE) begin
          powered_q <= !powered_q;
        end
      end
      if (wr_ok && wr_addr == `BDCIS_ADDR_CLEAR) begin
        if (wr_data == `BDCIS_CLEAR_ARM) begin
          clear_armed_q <= 1'b1;
        end else if (wr_data == `BDCIS_CLEAR_COMPLETE && clear_armed_q) begin
          clear_armed_q <= 1'b0;
          soft_reset_q <= 1'b1;
          reset_count_q <= reset_count_q + 2'b01;
        end else begin
          clear_armed_q <= 1'b0;
        end
      end
      if (soft_reset_q) begin
        conv_cfg_q <= `BDCIS_CONV_CFG_RST;
        dac_int_ref_q <= 1'b0;
        adc_int_ref_q <= 1'b0;
      end else if (wr_ok && wr_addr == `BDCIS_ADDR_CONV_CFG) begin
        conv_cfg_q <= wr_data;
        dac_int_ref_q <= wr_data[`BDCIS_REF_DAC_BIT];
        adc_int_ref_q <= wr_data[`BDCIS_REF_ADC_BIT];
      end
    end
  end

  // ====================================================================
  // Amplifier offset calibration and busy
  // A new start in the cycle of completion wins over the clear.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp_pend_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (soft_reset_q || !powered_q) begin
        amp_pend_q <= 1'b0;
      end else begin
        if (eng_done[0]) begin
          amp_pend_q <= 1'b0;
        end
        if (wr_ok && wr_addr == `BDCIS_ADDR_AMP_CAL && wr_data == `BDCIS_AMP_CAL_GO) begin
          amp_pend_q <= 1'b1;
        end
      end
      busy_q <= amp_pend_q || (|ch_pend) || (eng_active && !eng_done[NJOB-1]);
    end
  end

  assign eng_req[0] = amp_pend_q;
  assign eng_req[NJOB-1] = conv_req && powered_q;
  assign conv_done = eng_done[NJOB-1];

  bdcis_cal_engine #(
    .NJOB(NJOB),
    .CW(CW),
    .AMP_CYCLES(AMP_CAL_CYCLES[CW-1:0]),
    .CAL_CYCLES(DAC_CAL_CYCLES[CW-1:0]),
    .CONV_CYCLES(CONV_CYCLES[CW-1:0])
  ) u_engine (
    .clk(clk),
    .resetn(resetn),
    .abort(soft_reset_q || !powered_q),
    .req(eng_req),
    .active_q(eng_active),
    .done_q(eng_done)
  );

  // ====================================================================
  // Per-channel wiper and fine DAC sequencing
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      localparam [7:0] A_UP = `BDCIS_ADDR_UPPER + g;
      localparam [7:0] A_LO = `BDCIS_ADDR_LOWER + g;
      localparam [7:0] A_FB = `BDCIS_ADDR_FINE_BUF + g;
      localparam [7:0] A_FBC = `BDCIS_ADDR_FINE_BUF_CAL + g;
      localparam [7:0] A_FDC = `BDCIS_ADDR_FINE_DIRECT_CAL + g;
      localparam [7:0] A_DD = `BDCIS_ADDR_DIRECT_DAC + g;
      wire load;
      reg [CWV-1:0] up_buf_q;
      reg up_stg_q;
      reg up_cal_q;
      reg [CWV-1:0] up_tgt_q;
      reg up_run_q;
      reg [CWV-1:0] up_dac_q;
      reg [CWV-1:0] lo_buf_q;
      reg lo_stg_q;
      reg lo_cal_q;
      reg [CWV-1:0] lo_tgt_q;
      reg lo_run_q;
      reg [CWV-1:0] lo_dac_q;
      reg [FWV-1:0] fine_buf_q;
      reg fine_stg_q;
      reg fine_stg_cal_q;
      reg [FWV-1:0] fine_tgt_q;
      reg fine_pend_q;
      reg [FWV-1:0] fine_dac_q;

      assign load = wr_ok && wr_addr == `BDCIS_ADDR_LOAD && wr_data[g];
      assign ch_coarse_run[g] = up_run_q || lo_run_q;
      assign ch_fine_pend[g] = fine_pend_q;
      assign ch_pend[g] = up_run_q || lo_run_q || fine_pend_q;
      assign eng_req[1+g] = up_run_q || lo_run_q;
      assign eng_req[1+NCH+g] = fine_pend_q && !(up_run_q || lo_run_q);
      assign upper_dac[g*CWV +: CWV] = up_dac_q;
      assign lower_dac[g*CWV +: CWV] = lo_dac_q;
      assign fine_dac[g*FWV +: FWV] = fine_dac_q;

      // Wiper writes only stage a value; there is no calibrated path that
      // reaches a coarse DAC without the load strobe.
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          up_buf_q <= {CWV{1'b0}};
          up_stg_q <= 1'b0;
          up_cal_q <= 1'b0;
          up_tgt_q <= {CWV{1'b0}};
          up_run_q <= 1'b0;
          up_dac_q <= {CWV{1'b0}};
          lo_buf_q <= {CWV{1'b0}};
          lo_stg_q <= 1'b0;
          lo_cal_q <= 1'b0;
          lo_tgt_q <= {CWV{1'b0}};
          lo_run_q <= 1'b0;
          lo_dac_q <= {CWV{1'b0}};
        end else if (soft_reset_q) begin
          up_stg_q <= 1'b0;
          up_run_q <= 1'b0;
          up_dac_q <= {CWV{1'b0}};
          lo_stg_q <= 1'b0;
          lo_run_q <= 1'b0;
          lo_dac_q <= {CWV{1'b0}};
        end else begin
          if (eng_done[1+g]) begin
            up_run_q <= 1'b0;
            lo_run_q <= 1'b0;
            if (up_run_q) begin
              up_dac_q <= up_tgt_q;
            end
            if (lo_run_q) begin
              lo_dac_q <= lo_tgt_q;
            end
          end
          if (wr_ok && wr_addr == A_UP) begin
            up_buf_q <= wr_data[CWV-1:0];
            up_cal_q <= wr_data[`BDCIS_WIPER_CAL_BIT];
            up_stg_q <= 1'b1;
          end else if (load && up_stg_q) begin
            up_stg_q <= 1'b0;
          end
          if (wr_ok && wr_addr == A_LO) begin
            lo_buf_q <= wr_data[CWV-1:0];
            lo_cal_q <= wr_data[`BDCIS_WIPER_CAL_BIT];
            lo_stg_q <= 1'b1;
          end else if (load && lo_stg_q) begin
            lo_stg_q <= 1'b0;
          end
          if (load && up_stg_q) begin
            up_tgt_q <= up_buf_q;
            if (up_cal_q) begin
              up_run_q <= 1'b1;
            end else begin
              up_dac_q <= up_buf_q;
            end
          end
          if (load && lo_stg_q) begin
            lo_tgt_q <= lo_buf_q;
            if (lo_cal_q) begin
              lo_run_q <= 1'b1;
            end else begin
              lo_dac_q <= lo_buf_q;
            end
          end
        end
      end

      // Fine calibration waits behind the coarse run of its own channel.
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          fine_buf_q <= {FWV{1'b0}};
          fine_stg_q <= 1'b0;
          fine_stg_cal_q <= 1'b0;
          fine_tgt_q <= {FWV{1'b0}};
          fine_pend_q <= 1'b0;
          fine_dac_q <= {FWV{1'b0}};
        end else if (soft_reset_q) begin
          fine_stg_q <= 1'b0;
          fine_pend_q <= 1'b0;
          fine_dac_q <= {FWV{1'b0}};
        end else begin
          if (eng_done[1+NCH+g]) begin
            fine_pend_q <= 1'b0;
            fine_dac_q <= fine_tgt_q;
          end
          if (wr_ok && (wr_addr == A_FB || wr_addr == A_FBC)) begin
            fine_buf_q <= wr_data[FWV-1:0];
            fine_stg_q <= 1'b1;
            fine_stg_cal_q <= (wr_addr == A_FBC);
          end else if (load && fine_stg_q) begin
            fine_stg_q <= 1'b0;
          end
          if (wr_ok && wr_addr == A_FDC) begin
            fine_tgt_q <= wr_data[FWV-1:0];
            fine_pend_q <= 1'b1;
          end else if (load && fine_stg_q) begin
            if (fine_stg_cal_q) begin
              fine_tgt_q <= fine_buf_q;
              fine_pend_q <= 1'b1;
            end else begin
              fine_dac_q <= fine_buf_q;
            end
          end
          if (wr_ok && wr_addr == A_DD) begin
            fine_dac_q <= wr_data[FWV-1:0];
          end
        end
      end
    end
  endgenerate

  // ====================================================================
  // Register readback, one cycle after the request.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_q <= `BDCIS_ZERO16;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (!rd_en) begin
        rd_data_q <= `BDCIS_ZERO16;
      end else if (rd_addr == `BDCIS_ADDR_CONV_CFG) begin
        rd_data_q <= conv_cfg_q;
      end else if (rd_addr == `BDCIS_ADDR_POWER) begin
        rd_data_q <= power_q;
      end else if (rd_addr == `BDCIS_ADDR_STATUS) begin
        rd_data_q <= {busy_q, powered_q, clear_armed_q, amp_pend_q, eng_active,
                      reset_count_q, {(9-2*NCH){1'b0}}, ch_fine_pend, ch_coarse_run};
      end else begin
        rd_data_q <= `BDCIS_ZERO16;
      end
    end
  end

endmodule

`default_nettype wire

//--- bench/bdcis_chk.sv
// Port assertions for the bias DAC calibration sequencer.
`timescale 1ns/1ps
`default_nettype none
module bdcis_chk #(
  parameter NCH = 2,
  parameter AMP_CAL_CYCLES = 40,
  parameter CONV_CYCLES = 2
) (
  input wire clk,
  input wire resetn,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [15:0] wr_data,
  input wire conv_req,
  input wire conv_done,
  input wire [NCH*8-1:0] upper_dac,
  input wire [NCH*8-1:0] lower_dac,
  input wire [NCH*10-1:0] fine_dac,
  input wire powered_q,
  input wire dac_int_ref_q,
  input wire adc_int_ref_q,
  input wire soft_reset_q,
  input wire busy_q
);
  // ==========
  // Helpers
  localparam int B1 = AMP_CAL_CYCLES - 4;
  localparam int CB = CONV_CYCLES + 8;
  wire ok = wr_en && powered_q;
  wire fin = ok && wr_addr == 8'h68 && wr_data == 16'h0200;
  wire [9:0] wd10 = wr_data[9:0];
  wire wa0 = wr_addr[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_arm;
    ok && wr_addr == 8'h68 && wr_data == 16'h0100;
  endsequence
  sequence s_amp;
    ok && wr_addr == 8'h4e && wr_data == 16'h0002;
  endsequence
  // Busy must be high two cycles after the start and again B1 cycles later, then fall within ten cycles.
  sequence s_amp_busy;
    ##2 busy_q ##B1 busy_q ##[1:10] !busy_q;
  endsequence
  // ==========
  // Assertions
  AST_PWR: assert property (
    wr_en && wr_addr == 8'h64 && wr_data == 16'h0080 |=> powered_q != $past(powered_q))
    else $error("power toggle missed");
  AST_CLR: assert property (s_arm ##1 !wr_en ##1 fin |=> soft_reset_q)
    else $error("armed clear gave no reset");
  AST_CLR_ONLY: assert property (soft_reset_q |-> $past(fin))
    else $error("reset without completing write");
  AST_CLR_EFFECT: assert property (
    soft_reset_q |-> ##[0:1] ~|{dac_int_ref_q, adc_int_ref_q, upper_dac, lower_dac, fine_dac})
    else $error("soft reset left state");
  AST_CFG: assert property (
    ok && wr_addr == 8'h30 && wr_data == 16'h000a |=> dac_int_ref_q && adc_int_ref_q)
    else $error("internal references not selected");
  AST_AMP: assert property (s_amp |-> s_amp_busy)
    else $error("amplifier busy length wrong");
  AST_UPPER: assert property (ok && wr_addr[7:1] == 7'h08 && !busy_q |=> $stable(upper_dac))
    else $error("upper coarse changed on wiper write");
  AST_LOWER: assert property (ok && wr_addr[7:1] == 7'h09 && !busy_q |=> $stable(lower_dac))
    else $error("lower coarse changed on wiper write");
  AST_DIRECT: assert property (
    ok && wr_addr[7:1] == 7'h0d && !busy_q |=> (($past(wa0) ? fine_dac[19:10] : fine_dac[9:0]) == $past(wd10)))
    else $error("direct write not applied");
  AST_CONV: assert property ($rose(conv_req) && !busy_q |-> ##[1:CB] conv_done)
    else $error("conversion not served");
endmodule
bind bdcis_core bdcis_chk #(.NCH(NCH), .AMP_CAL_CYCLES(AMP_CAL_CYCLES), .CONV_CYCLES(CONV_CYCLES)) chk_u (
  .clk(clk), .resetn(resetn), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
  .conv_req(conv_req), .conv_done(conv_done), .upper_dac(upper_dac), .lower_dac(lower_dac),
  .fine_dac(fine_dac), .powered_q(powered_q), .dac_int_ref_q(dac_int_ref_q),
  .adc_int_ref_q(adc_int_ref_q), .soft_reset_q(soft_reset_q), .busy_q(busy_q));
`default_nettype wire

//--- bench/bdcis_host.sv
// Host controller model driving the sequencer's register strobes.
`timescale 1ns/1ps
`default_nettype none
module bdcis_host (
  input wire logic clk,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [15:0] wr_data,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [15:0] rd_data_q,
  input wire logic rd_valid_q,
  input wire logic busy_q
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 8'h00;
    rd_addr = 8'h00;
    wr_data = 16'h0000;
  end
  // Released lines show the inverse of the last value so stale data cannot pass for fresh.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    rd_addr = ~a;
    v = rd_valid_q;
    d = rd_data_q;
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (busy_q !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/test_bias_dac_calibration_init_sequencer.sv
// Self-checking bench of the bias DAC calibration sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_bias_dac_calibration_init_sequencer;
  localparam int AMP = 40;
  logic clk, resetn, conv_req;
  wire wr_en, rd_en, rd_valid_q, conv_done, powered_q, dac_int_ref_q, adc_int_ref_q, soft_reset_q, busy_q;
  wire [7:0] wr_addr, rd_addr;
  wire [15:0] wr_data, rd_data_q, upper_dac, lower_dac;
  wire [19:0] fine_dac;
  int bad_count, n_compared, cyc, m_pw, m_rc, n, early;
  logic [15:0] m_up, m_lo;
  logic [19:0] m_fi;
  logic [7:0] u, l;
  logic [9:0] f;
  bdcis_core #(.AMP_CAL_CYCLES(AMP), .DAC_CAL_CYCLES(4), .CONV_CYCLES(2)) dut_u (
    .clk(clk), .resetn(resetn), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .conv_req(conv_req), .conv_done(conv_done), .upper_dac(upper_dac), .lower_dac(lower_dac),
    .fine_dac(fine_dac), .powered_q(powered_q), .dac_int_ref_q(dac_int_ref_q),
    .adc_int_ref_q(adc_int_ref_q), .soft_reset_q(soft_reset_q), .busy_q(busy_q));
  bdcis_host host_u (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .busy_q(busy_q));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========
  // Checking tasks
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic v;
    host_u.rd(a, d, v);
    chk({v, d}, {1'b1, e});
  endtask
  task automatic pw;
    host_u.wr(8'h64, 16'h0080);
    m_pw = 1 - m_pw;
    chk(powered_q, m_pw[0]);
  endtask
  task automatic clr(input logic [15:0] d, input logic p);
    host_u.wr(8'h68, d);
    chk(soft_reset_q, p);
    if (p) begin
      @(negedge clk);
      chk(soft_reset_q, 1'b0);
      m_rc = (m_rc + 1) % 4;
      m_up = 16'h0000;
      m_lo = 16'h0000;
      m_fi = 20'h0_0000;
    end
  endtask
  task automatic stat;
    rdc(8'h1e, 16'h4000 | 16'(m_rc << 9));
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  // ==========
  // Main sequence
  initial begin
    resetn = 1'b0;
    conv_req = 1'b0;
    m_pw = 1;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    void'($urandom(32'h34c5));
    chk({powered_q, dac_int_ref_q, adc_int_ref_q, busy_q, upper_dac, lower_dac, fine_dac}, 64'h0080_0000_0000_0000);
    stat;
    rdc(8'h64, 16'h0000);
    rdc(8'hf0, 16'h0000);
    $display("test 1 done");
    pw;
    host_u.wr(8'h30, 16'h000a);
    chk(dac_int_ref_q, 1'b0);
    pw;
    clr(16'h0200, 1'b0);
    repeat (2) begin
      clr(16'h0100, 1'b0);
      clr(16'h0200, 1'b1);
    end
    stat;
    pw;
    pw;
    host_u.wr(8'h30, 16'h000a);
    chk({dac_int_ref_q, adc_int_ref_q}, 2'b11);
    rdc(8'h30, 16'h000a);
    rdc(8'h64, 16'h0080);
    host_u.wr(8'h4e, 16'h0002);
    n = 0;
    while (busy_q !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    host_u.wait_idle(n);
    chk(n >= AMP - 2 && n <= AMP + 8, 1'b1);
    $display("test 2 done");
    for (int g = 0; g < 2; g++) begin
      u = 8'($urandom);
      l = 8'($urandom);
      f = 10'($urandom);
      if (g == 0) host_u.wr(8'h10, {7'h00, 1'b1, u});
      host_u.wr(8'h12 + 8'(g), {7'h00, 1'b1, l});
      if (g == 1) host_u.wr(8'h11, {7'h00, 1'b1, u});
      chk({upper_dac, lower_dac}, {m_up, m_lo});
      host_u.wr(8'h1c, 16'h0001 << g);
      chk({upper_dac, lower_dac}, {m_up, m_lo});
      if (g == 0) host_u.wr(8'h18, {6'h00, f});
      else begin
        host_u.wr(8'h17, {6'h00, f});
        host_u.wr(8'h1c, 16'h0002);
      end
      m_up[8*g+:8] = u;
      m_lo[8*g+:8] = l;
      early = 0;
      n = 0;
      while ((busy_q !== 1'b0 || n < 2) && n < 300) begin
        @(negedge clk);
        n++;
        if (fine_dac[10*g+:10] !== m_fi[10*g+:10] && upper_dac[8*g+:8] !== u) early = 1;
      end
      m_fi[10*g+:10] = f;
      chk(early, 0);
      chk({upper_dac, lower_dac, fine_dac}, {m_up, m_lo, m_fi});
    end
    $display("test 3 done");
    f = 10'($urandom);
    u = 8'($urandom);
    host_u.wr(8'h1b, {6'h00, f});
    m_fi[19:10] = f;
    chk(fine_dac, m_fi);
    host_u.wr(8'h10, {8'h00, u});
    host_u.wr(8'h14, {6'h00, f});
    host_u.wr(8'h1c, 16'h0001);
    m_up[7:0] = u;
    m_fi[9:0] = f;
    chk(upper_dac, m_up);
    chk(fine_dac, m_fi);
    @(negedge clk);
    conv_req = 1'b1;
    n = 0;
    while (conv_done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    conv_req = 1'b0;
    chk(n > 0 && n <= 10, 1'b1);
    $display("test 4 done");
    clr(16'h0100, 1'b0);
    clr(16'h0200, 1'b1);
    chk({dac_int_ref_q, adc_int_ref_q, upper_dac, lower_dac, fine_dac}, 54'h0);
    stat;
    $display("test 5 done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
